// ### rtl/scp_pkg.sv
// serial port control package: sfr map, control bit positions, mode and carrier types
// assumes an 8-bit special-function-register space with bit addressing
package scp_pkg;
  // sfr byte addresses
  localparam logic [7:0] SCP_CTRL_ADDR = 8'h98; // serial_port_control
  localparam logic [7:0] SCP_DATA_ADDR = 8'h99; // serial_data_buffer
  localparam logic [7:0] SCP_CTRL_RESET = 8'h00; // control register reset value
  localparam logic [7:0] SCP_DATA_RESET = 8'h00; // receive buffer reset value
  // bit positions inside serial_port_control
  localparam int SCP_BIT_MODE_HI = 7; // mode_hi_or_frame_error
  localparam int SCP_BIT_MODE_LO = 6; // mode_lo
  localparam int SCP_BIT_MPQ = 5; // multiproc_qualify
  localparam int SCP_BIT_RX_EN = 4; // receive enable
  localparam int SCP_BIT_TX9 = 3; // tx_ninth_bit
  localparam int SCP_BIT_RX9 = 2; // rx_ninth_bit
  localparam int SCP_BIT_TXD = 1; // tx_done_flag
  localparam int SCP_BIT_RXD = 0; // rx_done_flag
  // shift-mode clock dividers, in system clock cycles per bit
  localparam logic [3:0] SCP_DIV_SLOW = 4'hc; // divide by 12
  localparam logic [3:0] SCP_DIV_FAST = 4'h2; // divide by 2
  // bits per frame as seen by the shifters
  localparam logic [3:0] SCP_BITS_SHIFT = 4'h8; // shift mode data bits
  localparam logic [3:0] SCP_TX_BITS_8 = 4'ha; // start, 8 data, stop
  localparam logic [3:0] SCP_TX_BITS_9 = 4'hb; // start, 8 data, ninth, stop
  localparam logic [3:0] SCP_RX_BITS_8 = 4'h9; // 8 data, stop
  localparam logic [3:0] SCP_RX_BITS_9 = 4'ha; // 8 data, ninth, stop
  // tx fifo
  localparam int SCP_FIFO_DEPTH = 4; // words
  // operating modes, in selector order
  typedef enum logic [1:0] {SCP_MODE_SHIFT, SCP_MODE_8VAR, SCP_MODE_9FIX,
                            SCP_MODE_9VAR} scp_mode_t;
  // sfr access from the cpu
  typedef struct packed {
    logic [7:0] addr; // byte address
    logic wr; // byte write strobe
    logic rd; // byte read strobe
    logic [7:0] wdata; // byte write data
    logic bit_wr; // single-bit write strobe
    logic [7:0] bit_addr; // bit address, byte address plus bit index
    logic bit_val; // value for single-bit write
  } scp_sfr_req_t;
endpackage

// ### rtl/scp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module scp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage flops
  logic [AW-1:0] wr_ptr_reg; // write index
  logic [AW-1:0] rd_ptr_reg; // read index
  logic [AW:0] count_reg; // words held
  logic push; // accepted write
  logic pop; // accepted read
  assign o_ready = count_reg < (AW+1)'(DEPTH); // room for one more word, empty included
  assign o_valid = count_reg != '0;
  assign o_data = mem_reg[rd_ptr_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  // storage write
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end
  // pointers and occupancy
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### rtl/scp_serial_port.sv
// serial port control: control register, tx/rx shifters, frame qualification
// assumes a byte sfr bus with bit addressing, a baud tick for modes 1..3 from outside
`timescale 1ns/1ps
module scp_serial_port #(
  parameter int FIFO_DEPTH = scp_pkg::SCP_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire scp_pkg::scp_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_frame_error_select,
  input wire logic i_baud_tick,
  input wire logic [7:0] i_given_addr,
  input wire logic [7:0] i_broadcast_addr,
  input wire logic i_rxd,
  output logic o_rxd_out,
  output logic o_rxd_oe,
  output logic o_txd,
  output logic o_tx_ready,
  output logic o_tx_done,
  output logic o_rx_done
);
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end
  typedef enum logic {SCP_RX_IDLE, SCP_RX_SHIFT} scp_rx_state_t;
  // control fields
  logic mode_hi_reg; // stored upper mode bit
  logic fe_reg; // frame error flag
  logic mode_lo_reg; // lower mode bit
  logic mpq_reg; // multiproc_qualify
  logic ren_reg; // receive enable
  logic tx9_reg; // tx_ninth_bit
  logic rx9_reg; // rx_ninth_bit
  logic ti_reg; // tx_done_flag
  logic ri_reg; // rx_done_flag
  logic [7:0] rx_data_reg; // receive buffer
  // engines
  logic tx_busy_reg; // transmitter shifting
  logic [10:0] tx_shift_reg; // outgoing bits, lsb first
  logic [3:0] tx_left_reg; // bits still to send
  scp_rx_state_t rx_state_reg; // receiver state
  logic [9:0] rx_shift_reg; // incoming bits, enter at top
  logic [3:0] rx_left_reg; // bits still to sample
  logic rxd_prev_reg; // line level one clock ago, for start edges
  logic [3:0] div_cnt_reg; // shift-mode bit timer
  // decode
  scp_pkg::scp_mode_t mode;
  logic mode0;
  logic [7:0] ctrl_view; // control byte as read
  logic ctrl_wr; // any write to control
  logic [7:0] ctrl_wr_val; // merged control write value
  logic [3:0] div_lim; // shift-mode divide
  logic m0_run;
  logic m0_tick;
  logic bit_tick; // one pulse per bit time
  logic [9:0] rx_new; // shift register after this sample
  logic rx_finish; // last bit sampled this cycle
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_stop;
  logic addr_hit;
  logic rx_accept; // frame qualifies for loading
  logic rx_load; // buffer and ninth bit load
  logic ti_set;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic data_push;

  // replace one bit of a byte, used by bit-addressed writes
  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] idx,
                                           input logic val);
    logic [7:0] res;
    res = old;
    res[idx] = val;
    return res;
  endfunction

  assign mode = scp_pkg::scp_mode_t'({mode_hi_reg, mode_lo_reg});
  assign mode0 = mode == scp_pkg::SCP_MODE_SHIFT;
  // bit 7 shows the error flag or the mode bit
  assign ctrl_view = {i_frame_error_select ? fe_reg : mode_hi_reg, mode_lo_reg, mpq_reg,
                      ren_reg, tx9_reg, rx9_reg, ti_reg, ri_reg};
  // byte write or bit write in the 98h..9fh bit range
  assign ctrl_wr = (i_sfr.wr && i_sfr.addr == scp_pkg::SCP_CTRL_ADDR) ||
                   (i_sfr.bit_wr && i_sfr.bit_addr[7:3] == scp_pkg::SCP_CTRL_ADDR[7:3]);
  assign ctrl_wr_val = (i_sfr.wr && i_sfr.addr == scp_pkg::SCP_CTRL_ADDR) ? i_sfr.wdata :
                       bit_merge(ctrl_view, i_sfr.bit_addr[2:0], i_sfr.bit_val);
  assign data_push = i_sfr.wr && i_sfr.addr == scp_pkg::SCP_DATA_ADDR;

  // shift-mode bit timer
  assign div_lim = mpq_reg ? scp_pkg::SCP_DIV_FAST : scp_pkg::SCP_DIV_SLOW;
  assign m0_run = mode0 && (tx_busy_reg || rx_state_reg == SCP_RX_SHIFT);
  assign m0_tick = m0_run && div_cnt_reg == div_lim - 4'h1;
  assign bit_tick = mode0 ? m0_tick : i_baud_tick;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_reg <= 4'h0;
    end else if (!m0_run || m0_tick) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  // control register fields, hardware sets win over software clears
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {mode_hi_reg, mode_lo_reg, mpq_reg, ren_reg, tx9_reg} <= scp_pkg::SCP_CTRL_RESET[7:3];
      fe_reg <= scp_pkg::SCP_CTRL_RESET[scp_pkg::SCP_BIT_MODE_HI];
    end else begin
      if (ctrl_wr) begin
        // bit 7 writes land on whichever meaning is selected
        if (!i_frame_error_select) mode_hi_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_MODE_HI];
        mode_lo_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_MODE_LO];
        mpq_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_MPQ];
        ren_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_RX_EN];
        tx9_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_TX9];
      end
      // frame error: stop bit low, sticky until software clears
      if (rx_finish && !mode0 && !rx_stop && i_frame_error_select) begin
        fe_reg <= 1'b1;
      end else if (ctrl_wr && i_frame_error_select) begin
        fe_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_MODE_HI];
      end
    end
  end

  // done flags and receive capture
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ti_reg <= scp_pkg::SCP_CTRL_RESET[scp_pkg::SCP_BIT_TXD];
      ri_reg <= scp_pkg::SCP_CTRL_RESET[scp_pkg::SCP_BIT_RXD];
      rx9_reg <= scp_pkg::SCP_CTRL_RESET[scp_pkg::SCP_BIT_RX9];
      rx_data_reg <= scp_pkg::SCP_DATA_RESET;
    end else begin
      if (ti_set) ti_reg <= 1'b1;
      else if (ctrl_wr) ti_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_TXD];
      if (rx_load) ri_reg <= 1'b1;
      else if (ctrl_wr) ri_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_RXD];
      if (rx_load && !mode0) rx9_reg <= rx_ninth;
      else if (ctrl_wr) rx9_reg <= ctrl_wr_val[scp_pkg::SCP_BIT_RX9];
      if (rx_load) rx_data_reg <= rx_byte;
    end
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr.rd && i_sfr.addr == scp_pkg::SCP_CTRL_ADDR) begin
      o_sfr_rdata <= ctrl_view;
    end else if (i_sfr.rd && i_sfr.addr == scp_pkg::SCP_DATA_ADDR) begin
      o_sfr_rdata <= rx_data_reg;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // transmit data waits in the fifo; a full fifo drops the write
  scp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_valid(data_push),
    .o_ready(o_tx_ready),
    .i_data(i_sfr.wdata),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );
  // shift mode is half duplex, so no load while receiving there
  assign fifo_pop = !tx_busy_reg && !(mode0 && rx_state_reg == SCP_RX_SHIFT);
  // done after the 8th bit in shift mode, else when the stop bit starts
  assign ti_set = tx_busy_reg && bit_tick && tx_left_reg == (mode0 ? 4'h1 : 4'h2);

  // transmitter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 11'h7ff;
      tx_left_reg <= 4'h0;
    end else if (fifo_pop && fifo_valid) begin
      tx_busy_reg <= 1'b1;
      case (mode)
        scp_pkg::SCP_MODE_SHIFT: begin
          tx_shift_reg <= {3'h7, fifo_data};
          tx_left_reg <= scp_pkg::SCP_BITS_SHIFT;
        end
        scp_pkg::SCP_MODE_8VAR: begin
          tx_shift_reg <= {2'h3, fifo_data, 1'b0};
          tx_left_reg <= scp_pkg::SCP_TX_BITS_8;
        end
        default: begin
          tx_shift_reg <= {1'b1, tx9_reg, fifo_data, 1'b0};
          tx_left_reg <= scp_pkg::SCP_TX_BITS_9;
        end
      endcase
    end else if (tx_busy_reg && bit_tick) begin
      tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
      if (tx_left_reg == 4'h1) tx_busy_reg <= 1'b0;
    end
  end

  // pins: shift mode puts data on the rx pin and a clock on the tx pin
  assign o_rxd_oe = mode0 && tx_busy_reg;
  assign o_rxd_out = tx_shift_reg[0];
  assign o_txd = mode0 ? !(m0_run && div_cnt_reg < (div_lim >> 1)) :
                 (tx_busy_reg ? tx_shift_reg[0] : 1'b1);
  assign o_tx_done = ti_reg;
  assign o_rx_done = ri_reg;

  // frame fields after the final sample
  assign rx_new = {i_rxd, rx_shift_reg[9:1]};
  assign rx_finish = rx_state_reg == SCP_RX_SHIFT && bit_tick && rx_left_reg == 4'h1;
  always_comb begin
    rx_byte = rx_new[7:0];
    rx_ninth = rx_new[8];
    rx_stop = rx_new[9];
    case (mode)
      scp_pkg::SCP_MODE_SHIFT: begin
        rx_byte = rx_new[9:2];
      end
      scp_pkg::SCP_MODE_8VAR: begin
        rx_byte = rx_new[8:1];
        rx_ninth = rx_new[9];
      end
      default: begin
        rx_byte = rx_new[7:0];
      end
    endcase
  end
  assign addr_hit = rx_byte == i_given_addr || rx_byte == i_broadcast_addr;
  // qualification per mode; shift mode always qualifies
  always_comb begin
    case (mode)
      scp_pkg::SCP_MODE_SHIFT: rx_accept = 1'b1;
      scp_pkg::SCP_MODE_8VAR: rx_accept = !mpq_reg || (rx_stop && addr_hit);
      default: rx_accept = !mpq_reg || (rx_ninth && addr_hit);
    endcase
  end
  // a pending unread frame blocks loading
  assign rx_load = rx_finish && rx_accept && !ri_reg;

  // receiver
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state_reg <= SCP_RX_IDLE;
      rx_shift_reg <= 10'h000;
      rx_left_reg <= 4'h0;
      rxd_prev_reg <= 1'b1; // idle line level, so no false edge after reset
    end else begin
      rxd_prev_reg <= i_rxd;
      case (rx_state_reg)
        SCP_RX_IDLE: begin
          if (mode0 && ren_reg && !ri_reg && !tx_busy_reg) begin
            rx_state_reg <= SCP_RX_SHIFT;
            rx_left_reg <= scp_pkg::SCP_BITS_SHIFT;
          end else if (!mode0 && ren_reg && rxd_prev_reg && !i_rxd) begin // low stop is no start
            rx_state_reg <= SCP_RX_SHIFT;
            rx_left_reg <= (mode == scp_pkg::SCP_MODE_8VAR) ? scp_pkg::SCP_RX_BITS_8 :
                           scp_pkg::SCP_RX_BITS_9;
          end
        end
        SCP_RX_SHIFT: begin
          if (!mode0 && !ren_reg) begin
            rx_state_reg <= SCP_RX_IDLE;
          end else if (bit_tick) begin
            rx_shift_reg <= rx_new;
            rx_left_reg <= rx_left_reg - 4'h1;
            if (rx_left_reg == 4'h1) rx_state_reg <= SCP_RX_IDLE;
          end
        end
        default: rx_state_reg <= SCP_RX_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_div_slow;
    m0_tick && !mpq_reg && tx_busy_reg && tx_left_reg > 4'h1 && !ctrl_wr |-> ##12 m0_tick;
  endproperty
  a_div_slow: assert property (p_div_slow) else $error("slow shift clock not /12");
  property p_div_fast;
    m0_tick && mpq_reg && tx_busy_reg && tx_left_reg > 4'h1 && !ctrl_wr |-> ##2 m0_tick;
  endproperty
  a_div_fast: assert property (p_div_fast) else $error("fast shift clock not /2");
  property p_fe_set;
    rx_finish && !mode0 && !rx_stop && i_frame_error_select |=> fe_reg;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("frame error not flagged");
  property p_fe_read;
    i_sfr.rd && i_sfr.addr == scp_pkg::SCP_CTRL_ADDR && i_frame_error_select
      |=> o_sfr_rdata[7] == $past(fe_reg);
  endproperty
  a_fe_read: assert property (p_fe_read) else $error("bit 7 does not show frame error");
  property p_mp1;
    rx_finish && mode == scp_pkg::SCP_MODE_8VAR && mpq_reg && !rx_stop
      |=> rx_data_reg == $past(rx_data_reg);
  endproperty
  a_mp1: assert property (p_mp1) else $error("mode 1 frame with low stop loaded");
  property p_mp23;
    rx_finish && !mode0 && mode != scp_pkg::SCP_MODE_8VAR && mpq_reg && !rx_ninth
      |=> rx_data_reg == $past(rx_data_reg);
  endproperty
  a_mp23: assert property (p_mp23) else $error("ninth bit low frame loaded");
  property p_ren;
    rx_state_reg == SCP_RX_IDLE && !ren_reg |=> rx_state_reg == SCP_RX_IDLE;
  endproperty
  a_ren: assert property (p_ren) else $error("reception without enable");
  property p_ti;
    ti_set |=> ti_reg ##1 (ti_reg || $past(ctrl_wr));
  endproperty
  a_ti: assert property (p_ti) else $error("tx done not raised");
  property p_ri;
    rx_finish && rx_accept && !ri_reg |=> ri_reg && rx_data_reg == $past(rx_byte);
  endproperty
  a_ri: assert property (p_ri) else $error("accepted frame not delivered");
  c_tx_uart: cover property (ti_set && !mode0);
  c_rx_mode0: cover property (rx_load && mode0);
  c_rx_reject: cover property (rx_finish && !rx_accept);
  c_fe: cover property (!fe_reg ##1 fe_reg);
endmodule

// ### verification/scp_remote_node.sv
// remote serial node: bit-rate tick, frame sender and frame catcher
// assumes 16 system clocks per bit; ticks fall mid-bit for the receiver
`timescale 1ns/1ps
module scp_remote_node (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_tick,
  output logic o_rxd
);
  logic [3:0] cnt_reg = 4'h0; // bit phase
  // free-running phase, moved just after each edge
  always @(posedge i_clk) begin
    #1 cnt_reg = cnt_reg + 4'h1;
  end
  assign o_tick = (cnt_reg == 4'h8); // one tick each 16 clocks
  initial o_rxd = 1'b1; // idle line pulled high
  // start, 8 data lsb first, optional ninth, stop, then idle
  task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                      input logic stp);
    logic [10:0] f;
    int n;
    f = nine ? {1'b1, stp, b9, d} : {2'b11, stp, d};
    n = nine ? 10 : 9;
    @(posedge i_clk iff cnt_reg == 4'h8);
    #1 o_rxd = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk iff cnt_reg == 4'hf);
      #1 o_rxd = f[i];
    end
    @(posedge i_clk iff cnt_reg == 4'hf);
    #1 o_rxd = 1'b1;
  endtask
  // find a start bit, then gather n bits sampled between ticks
  task automatic catch_frame(input int n, output logic [8:0] v);
    v = 9'h000;
    for (int k = 0; k < 40 && i_txd !== 1'b0; k++) begin
      @(posedge i_clk iff cnt_reg == 4'h0);
    end
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk iff cnt_reg == 4'h0);
      v[i] = i_txd;
    end
  endtask
endmodule

// ### verification/scp_serial_port_test.sv
// self-checking bench for the serial port control block
// assumes the remote node model drives the line side and the bit tick
`timescale 1ns/1ps
module scp_serial_port_test;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  scp_pkg::scp_sfr_req_t sfr = '0; // cpu sfr request
  logic sel = 1'b0; // frame error select
  logic [7:0] rdata;
  logic rxd_out, rxd_oe, txd, tx_ready, tx_done, rx_done, tick, node_rxd;
  logic [8:0] v; // read-back value
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 i_clk = ~i_clk; // 40 MHz
  scp_serial_port scp_serial_port_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_frame_error_select(sel), .i_baud_tick(tick), .i_given_addr(8'h12),
    .i_broadcast_addr(8'hff), .i_rxd(rxd_oe ? rxd_out : node_rxd),
    .o_rxd_out(rxd_out), .o_rxd_oe(rxd_oe), .o_txd(txd), .o_tx_ready(tx_ready),
    .o_tx_done(tx_done), .o_rx_done(rx_done));
  scp_remote_node scp_remote_node_inst (
    .i_clk(i_clk), .i_txd(txd), .o_tick(tick), .o_rxd(node_rxd));
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // advance to just after the next edge
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    step();
    sfr.wr = 1'b0;
  endtask
  task automatic bw(input logic [7:0] ba, input logic b);
    step();
    sfr.bit_addr = ba;
    sfr.bit_val = b;
    sfr.bit_wr = 1'b1;
    step();
    sfr.bit_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    step();
    sfr.addr = a;
    sfr.rd = 1'b1;
    step();
    sfr.rd = 1'b0;
    d = {1'b0, rdata};
  endtask
  // back-to-back buffer writes, first one placed just after a tick
  task automatic burst(input logic [7:0] base, input int n);
    @(posedge i_clk iff scp_remote_node_inst.cnt_reg == 4'h8);
    #1 sfr.addr = 8'h99;
    sfr.wr = 1'b1;
    for (int i = 0; i < n; i++) begin
      sfr.wdata = base + 8'(i);
      step();
    end
    sfr.wr = 1'b0;
  endtask
  // bounded wait on a done flag
  task automatic wait_flag(input logic is_rx);
    for (int k = 0; k < 400 && (is_rx ? rx_done : tx_done) !== 1'b1; k++) step();
  endtask
  task automatic t_regs();
    rd(8'h98, v);
    chk("ctrl reset", 9'h000, v);
    rd(8'h9b, v);
    chk("unmapped", 9'h000, v);
    bw(8'h9c, 1'b1);
    rd(8'h98, v);
    chk("bit set", 9'h010, v);
  endtask
  // mode 1 transmit, buffer filled to refusal then drained, then a mode 3 frame with its ninth bit
  task automatic t_tx();
    logic [8:0] got;
    wr(8'h98, 8'h40);
    fork
      begin
        burst(8'ha0, 6);
        chk("fifo full", 9'h000, {8'h00, tx_ready});
      end
      for (int i = 0; i < 5; i++) begin
        scp_remote_node_inst.catch_frame(8, got);
        chk("tx byte", {1'b0, 8'ha0 + 8'(i)}, got);
      end
    join
    chk("tx done", 9'h001, {8'h00, tx_done});
    bw(8'h99, 1'b0);
    chk("tx done clr", 9'h000, {8'h00, tx_done});
    wr(8'h98, 8'hc8);
    fork
      burst(8'h5a, 1);
      scp_remote_node_inst.catch_frame(9, got);
    join
    chk("tx ninth", 9'h15a, got);
  endtask
  task automatic t_rx1();
    wr(8'h98, 8'h40);
    scp_remote_node_inst.send(8'h3c, 1'b0, 1'b0, 1'b0);
    chk("rx off", 9'h000, {8'h00, rx_done});
    wr(8'h98, 8'h50);
    scp_remote_node_inst.send(8'h3c, 1'b0, 1'b0, 1'b0);
    wait_flag(1'b1);
    rd(8'h98, v);
    chk("ctrl rx", 9'h051, v);
    rd(8'h99, v);
    chk("rx byte", 9'h03c, v);
  endtask
  task automatic t_mpq();
    wr(8'h98, 8'h70);
    scp_remote_node_inst.send(8'h34, 1'b0, 1'b0, 1'b1);
    chk("no match", 9'h000, {8'h00, rx_done});
    scp_remote_node_inst.send(8'h12, 1'b0, 1'b0, 1'b0);
    chk("stop low", 9'h000, {8'h00, rx_done});
    scp_remote_node_inst.send(8'hff, 1'b0, 1'b0, 1'b1);
    wait_flag(1'b1);
    rd(8'h98, v);
    chk("bcast ctrl", 9'h075, v);
    bw(8'h98, 1'b0);
    scp_remote_node_inst.send(8'h12, 1'b0, 1'b0, 1'b1);
    wait_flag(1'b1);
    rd(8'h99, v);
    chk("given byte", 9'h012, v);
  endtask
  task automatic t_fe();
    sel = 1'b1;
    wr(8'h98, 8'h50);
    scp_remote_node_inst.send(8'h5c, 1'b0, 1'b0, 1'b0);
    wait_flag(1'b1);
    rd(8'h98, v);
    chk("fe set", 9'h0d1, v);
    bw(8'h9f, 1'b0);
    rd(8'h98, v);
    chk("fe clr", 9'h051, v);
    sel = 1'b0;
    rd(8'h98, v);
    chk("mode kept", 9'h051, v);
  endtask
  task automatic t_mode2();
    wr(8'h98, 8'hb0);
    scp_remote_node_inst.send(8'h12, 1'b1, 1'b0, 1'b1);
    chk("ninth low", 9'h000, {8'h00, rx_done});
    scp_remote_node_inst.send(8'h12, 1'b1, 1'b1, 1'b1);
    wait_flag(1'b1);
    rd(8'h98, v);
    chk("ninth high", 9'h0b5, v);
    wr(8'h98, 8'h90);
    scp_remote_node_inst.send(8'h77, 1'b1, 1'b0, 1'b1);
    wait_flag(1'b1);
    rd(8'h98, v);
    chk("mpq off", 9'h091, v);
  endtask
  // shift mode: fall-to-fall period, data order on the rx pin, then a receive
  task automatic t_shift(input logic [7:0] ctl, input int per, input logic [7:0] d);
    int n;
    logic [7:0] sh;
    sh = 8'h00;
    wr(8'h98, ctl);
    burst(d, 1);
    for (n = 0; n < 40 && txd !== 1'b0; n++) step();
    chk("pin drive", 9'h001, {8'h00, rxd_oe});
    fork
      // data bit taken at each rising shift clock
      for (int b = 0; b < 8; b++) begin
        @(posedge txd);
        sh[b] = rxd_out;
      end
      begin
        n = 0;
        while (n < 40 && txd === 1'b0) begin
          step();
          n++;
        end
        while (n < 40 && txd === 1'b1) begin
          step();
          n++;
        end
      end
    join
    chk("shift period", 9'(per), 9'(n));
    chk("shift data", {1'b0, d}, {1'b0, sh});
    wait_flag(1'b0);
    chk("shift done", 9'h001, {8'h00, tx_done});
    // enable with rx flag clear starts a shift-mode receive of the idle line
    bw(8'h9c, 1'b1);
    wait_flag(1'b1);
    rd(8'h99, v);
    chk("shift rx", 9'h0ff, v);
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    t_regs();
    t_tx();
    t_rx1();
    t_mpq();
    t_fe();
    t_mode2();
    t_shift(8'h00, 12, 8'h93);
    t_shift(8'h20, 2, 8'h3a);
    close_out();
  end
endmodule
